// File: mult_accum_unit.sv
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mult_accum_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        compute_bank_start,
  input  wire logic        compute_bank_done,
  input  wire logic [39:0] compute_bank_result,
  output logic             irq
);
  import mac_access_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic reg_id_t decode(input logic [7:0] a);
    decode = REG_NONE;
    if (a[1:0] == 2'h0)
    begin
      if (a <= `OFS_ACC4) decode = REG_ACC;
      else if (a == `OFS_CTL) decode = REG_CTL;
      else if (a == `OFS_STAT) decode = REG_STAT;
      else if (a == `OFS_IRQ_STAT) decode = REG_ISTAT;
      else if (a == `OFS_IRQ_MASK) decode = REG_IMASK;
      else if (a >= `OFS_FIN0 && a <= `OFS_FIN4) decode = REG_FIN;
    end
  endfunction : decode

  function automatic logic [2:0] acc_idx(input logic [7:0] a);
    acc_idx = a[4:2];
  endfunction : acc_idx

  // Reference slice, sign extended then shifted
  function automatic logic [7:0] ref_byte(
    input logic [39:0] acc,
    input logic [2:0]  k,
    input logic [2:0]  s
  );
    logic [79:0] ext;
    ext      = {{40{acc[39]}}, acc} >> ({k, 3'h0} + {3'h0, s});
    ref_byte = ext[7:0];
  endfunction : ref_byte

  function automatic logic [39:0] low_mask(input logic [2:0] s);
    low_mask = ~(40'hFF_FFFF_FFFF << s);
  endfunction : low_mask

  unit_link_if lk ();

  logic [7:0]  aw_addr_q;
  logic        aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_held_q;
  logic        do_write;
  logic        ar_take;
  reg_id_t     wr_sel;
  reg_id_t     rd_sel;
  logic [31:0] rd_val;
  logic [1:0]  rd_resp;
  logic [6:0]  ctl_q;
  logic [39:0] host_acc_q;
  logic [39:0] compute_bank_acc_q;
  logic [1:0]  istat_q;
  logic [1:0]  istat_d;
  logic [1:0]  imask_q;
  logic [1:0]  imask_d;
  logic [1:0]  iclr;
  logic        wr_acc;
  logic        rd_release;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  acc_shift u_shift (
    .lk (lk.shift)
  );

  bank_status u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lk      (lk.bank)
  );

  // Shift setup taken from the control value at each access
  assign lk.acc_val    = host_acc_q;
  assign lk.lshift     = ctl_q[`CTL_LSHIFT_LSB +: 3];
  assign lk.rshift     = ctl_q[`CTL_RSHIFT_LSB +: 3];
  assign lk.fill       = ctl_q[`CTL_FILL_BIT];
  assign lk.wr_idx     = acc_idx(aw_addr_q);
  assign lk.wr_byte    = w_data_q[7:0];
  assign lk.rd_idx     = acc_idx(s_axi_araddr);
  assign lk.compute_bank_start = compute_bank_start;
  assign lk.compute_bank_done  = compute_bank_done;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_sel   = decode(aw_addr_q);
  assign wr_acc   = do_write && (wr_sel == REG_ACC || wr_sel == REG_FIN);

  // Address and data holding, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q     <= s_axi_awaddr;
        aw_held_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (do_write)
      begin
        aw_held_q     <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      else
        s_axi_awready <= !aw_held_q;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_held_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (do_write)
      begin
        w_held_q     <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      else
        s_axi_wready <= !w_held_q;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control register, low byte lane only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl_q <= `CTL_RESET;
    else if (do_write && wr_sel == REG_CTL && w_strb_q[0])
      ctl_q <= w_data_q[6:0];
  end

  // Swap request and result discard toward the bank logic
  assign lk.swap_req    = do_write && wr_sel == REG_STAT && w_strb_q[0] &&
                          w_data_q[7:0] == `SWAP_CODE;
  assign lk.release_req = (do_write && wr_sel != REG_STAT &&
                           wr_sel != REG_NONE) || rd_release;

  // Host accumulator: bank swap or shifted byte load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      host_acc_q <= 40'h00_0000_0000;
    else if (lk.swap_fire)
      host_acc_q <= compute_bank_acc_q;
    else if (wr_acc && w_strb_q[0])
      host_acc_q <= lk.acc_merged;
  end

  // Compute bank result capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compute_bank_acc_q <= 40'h00_0000_0000;
    else if (compute_bank_done && lk.compute_bank_st == BANK_IN_PROG)
      compute_bank_acc_q <= compute_bank_result;
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_take    = s_axi_arvalid && s_axi_arready;
  assign rd_sel     = decode(s_axi_araddr);
  assign rd_release = ar_take && (rd_sel == REG_FIN ||
                      (rd_sel == REG_ACC &&
                       s_axi_araddr == `OFS_ACC4));

  // Read data select
  always_comb
  begin
    rd_val  = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    case (rd_sel)
      REG_ACC, REG_FIN: rd_val = {24'h00_0000, lk.rd_byte};
      REG_CTL:   rd_val = {25'h000_0000, ctl_q};
      REG_STAT:  rd_val = {28'h000_0000, lk.compute_bank_st, lk.host_st};
      REG_ISTAT: rd_val = {30'h0000_0000, istat_q};
      REG_IMASK: rd_val = {30'h0000_0000, imask_q};
      default:   rd_resp = `RESP_SLVERR;
    endcase
  end

  // Read response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_resp;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
      s_axi_arready <= !s_axi_rvalid;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign iclr = (do_write && wr_sel == REG_ISTAT && w_strb_q[0]) ?
                w_data_q[1:0] : 2'h0;

  // Sticky events, a new event beats a clear
  always_comb
  begin
    istat_d = istat_q & ~iclr;
    istat_d[`IRQ_COMPUTE_BANK_DONE]  = istat_d[`IRQ_COMPUTE_BANK_DONE] | lk.done_evt;
    istat_d[`IRQ_HOST_EMPTY] = istat_d[`IRQ_HOST_EMPTY] | lk.empty_evt;
    imask_d = (do_write && wr_sel == REG_IMASK && w_strb_q[0]) ?
              w_data_q[1:0] : imask_q;
  end

  // Status, mask and output level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      istat_q <= 2'h0;
      imask_q <= `IRQ_MASK_RESET;
      irq     <= 1'b0;
    end
    else
    begin
      istat_q <= istat_d;
      imask_q <= imask_d;
      irq     <= |(istat_d & imask_d);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  read_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && (rd_sel == REG_ACC || rd_sel == REG_FIN) |=>
    s_axi_rdata[7:0] == ref_byte($past(host_acc_q), $past(lk.rd_idx),
                                 $past(lk.rshift)))
    else $error("accumulator read byte mismatch");

  read_sign_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && s_axi_araddr == `OFS_ACC4 && lk.rshift != 3'h0 |=>
    s_axi_rdata[7] == $past(host_acc_q[39]))
    else $error("top byte lost sign copy");

  top_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && s_axi_araddr == `OFS_ACC4 && lk.host_st == BANK_DONE |=>
    lk.host_st == BANK_EMPTY)
    else $error("top byte read left host bank done");

  write_discard_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && !(wr_sel inside {REG_STAT, REG_NONE}) &&
    lk.host_st == BANK_DONE |=> lk.host_st == BANK_EMPTY)
    else $error("register write kept done result");

  plain_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_acc && w_strb_q[0] && aw_addr_q == `OFS_ACC0 &&
    lk.lshift == 3'h0 && !lk.swap_fire |=>
    host_acc_q[7:0] == $past(w_data_q[7:0]))
    else $error("unshifted byte zero write wrong");

  fill_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_acc && w_strb_q[0] && aw_addr_q == `OFS_ACC0 &&
    !lk.swap_fire |=>
    (host_acc_q & low_mask($past(lk.lshift))) ==
    ($past(lk.fill) ? low_mask($past(lk.lshift)) : 40'h00_0000_0000))
    else $error("vacated low bits not filled");

  swap_banks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lk.swap_req && lk.host_st == BANK_EMPTY && lk.compute_bank_st == BANK_DONE |=>
    lk.host_st == BANK_DONE && lk.compute_bank_st == BANK_EMPTY &&
    host_acc_q == $past(compute_bank_acc_q))
    else $error("swap code did not swap banks");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lk.done_evt && imask_d[`IRQ_COMPUTE_BANK_DONE] |=>
    irq && istat_q[`IRQ_COMPUTE_BANK_DONE])
    else $error("interrupt level not matching status and mask");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid && (s_axi_bresp == `RESP_SLVERR) ==
    ($past(wr_sel) == REG_NONE))
    else $error("write response missing or wrong");
endmodule : mult_accum_unit

// File: mac_access_consts.svh
// Function
// - Compute_bank finishing while host bank done: compute_bank goes done, host stays done
// - Final read of a block input into any accumulator byte empties done host
// - Any read of the top accumulator byte empties a done host bank
// - Writing any unit register but status discards a done host result
// - Control bits 2:0 give the left shift used on accumulator writes
// - Write left shift equals load shift, 0 to 7, over 40 bits
// - Control bit 6 fills every low bit vacated by the write shift
// - Zero load shift stores byte k unchanged into accumulator bits 8k+7:8k
// - Shift s: byte 0 fills 7+s:0, others land s higher, top trimmed
// - Control bits 5:3 give the right shift used on accumulator reads
// - Reads are right shifted by the result shift, 0 to 7 bits
// - Bits vacated by the read shift copy accumulator bit 39
// - Zero result shift reads byte k as accumulator bits 8k+7:8k
// - Result shift s reads byte k from bit 8k+s, sign copied above
// - Swap code to status with host empty, compute_bank done swaps banks
`ifndef MAC_ACCESS_CONSTS_SVH
`define MAC_ACCESS_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_ACC0      8'h00
`define OFS_ACC4      8'h10
`define OFS_CTL       8'h14
`define OFS_STAT      8'h18
`define OFS_IRQ_STAT  8'h1C
`define OFS_IRQ_MASK  8'h20
`define OFS_FIN0      8'h40
`define OFS_FIN4      8'h50

// ----------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------
`define CTL_LSHIFT_LSB 0
`define CTL_RSHIFT_LSB 3
`define CTL_FILL_BIT   6
`define CTL_RESET      7'h00
`define SWAP_CODE      8'h80
`define ST_EMPTY_CODE  2'h0
`define ST_READY_CODE  2'h1
`define ST_INPROG_CODE 2'h3
`define ST_DONE_CODE   2'h2
`define IRQ_COMPUTE_BANK_DONE  0
`define IRQ_HOST_EMPTY 1
`define IRQ_MASK_RESET 2'h0
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// File: mac_access_pkg.sv
`include "mac_access_consts.svh"
package mac_access_pkg;
  // Bank status, Gray along empty, ready, in progress, done
  typedef enum logic [1:0] {
    BANK_EMPTY   = `ST_EMPTY_CODE,
    BANK_READY   = `ST_READY_CODE,
    BANK_IN_PROG = `ST_INPROG_CODE,
    BANK_DONE    = `ST_DONE_CODE
  } bank_st_t;

  // Decoded register targets
  typedef enum logic [2:0] {
    REG_NONE, REG_ACC, REG_FIN, REG_CTL, REG_STAT, REG_ISTAT, REG_IMASK
  } reg_id_t;
endpackage : mac_access_pkg

// File: unit_link_if.sv
`timescale 1ns/1ps
interface unit_link_if;
  import mac_access_pkg::*;
  logic [39:0] acc_val;
  logic [39:0] acc_merged;
  logic [2:0]  wr_idx;
  logic [2:0]  rd_idx;
  logic [7:0]  wr_byte;
  logic [7:0]  rd_byte;
  logic [2:0]  lshift;
  logic [2:0]  rshift;
  logic        fill;
  logic        compute_bank_start;
  logic        compute_bank_done;
  logic        release_req;
  logic        swap_req;
  logic        swap_fire;
  logic        done_evt;
  logic        empty_evt;
  bank_st_t    host_st;
  bank_st_t    compute_bank_st;

  modport shift (input acc_val, wr_idx, rd_idx, wr_byte, lshift, rshift,
                 fill, output acc_merged, rd_byte);
  modport bank (input compute_bank_start, compute_bank_done, release_req, swap_req,
                output swap_fire, done_evt, empty_evt, host_st, compute_bank_st);
endinterface : unit_link_if

// File: acc_shift.sv
`timescale 1ns/1ps
module acc_shift (
  unit_link_if.shift lk
);
  import mac_access_pkg::*;

  // ----------------------------------------------------------------
  // Byte placement with left shift and fill
  // ----------------------------------------------------------------
  function automatic logic [39:0] merge_byte(
    input logic [39:0] acc,
    input logic [2:0]  k,
    input logic [7:0]  d,
    input logic [2:0]  s,
    input logic        f
  );
    logic [5:0]  sh;
    logic [47:0] val;
    logic [47:0] msk;
    logic [47:0] fmsk;
    sh   = {k, 3'h0} + {3'h0, s};
    val  = {40'h0, d} << sh;
    msk  = {40'h0, 8'hFF} << sh;
    fmsk = ~(48'hFFFF_FFFF_FFFF << s);
    if (k == 3'h0)
    begin
      msk = msk | fmsk;
      val = val | (f ? fmsk : 48'h0);
    end
    merge_byte = (acc & ~msk[39:0]) | (val[39:0] & msk[39:0]);
  endfunction : merge_byte

  logic signed [39:0] shifted;
  logic [5:0]         rpos;
  logic [2:0]         widx;

  // Write merge and sign-extending read slice
  always_comb
  begin
    widx          = (lk.wr_idx > 3'h4) ? 3'h0 : lk.wr_idx;
    lk.acc_merged = merge_byte(lk.acc_val, widx, lk.wr_byte,
                               lk.lshift, lk.fill);
    shifted       = $signed(lk.acc_val) >>> lk.rshift;
    rpos          = (lk.rd_idx > 3'h4) ? 6'h0 : {lk.rd_idx, 3'h0};
    lk.rd_byte    = shifted[rpos +: 8];
  end
endmodule : acc_shift

// File: bank_status.sv
`timescale 1ns/1ps
module bank_status (
  input wire logic aclk,
  input wire logic aresetn,
  unit_link_if.bank lk
);
  import mac_access_pkg::*;

  bank_st_t host_q;
  bank_st_t host_d;
  bank_st_t compute_bank_q;
  bank_st_t compute_bank_d;
  logic     swap_ok;

  assign swap_ok = lk.swap_req && (host_q == BANK_EMPTY) &&
                   (compute_bank_q == BANK_DONE);

  // Compute bank progression
  always_comb
  begin
    compute_bank_d = compute_bank_q;
    case (compute_bank_q)
      BANK_EMPTY:   if (lk.compute_bank_start) compute_bank_d = BANK_IN_PROG;
      BANK_IN_PROG: if (lk.compute_bank_done) compute_bank_d = BANK_DONE;
      BANK_DONE:
      begin
        if (swap_ok) compute_bank_d = BANK_EMPTY;
        else if (lk.compute_bank_start) compute_bank_d = BANK_IN_PROG;
      end
      default:      compute_bank_d = BANK_EMPTY;
    endcase
  end

  // Host bank progression, compute_bank bank untouched here
  always_comb
  begin
    host_d = host_q;
    case (host_q)
      BANK_EMPTY: if (swap_ok) host_d = BANK_DONE;
      BANK_DONE:  if (lk.release_req) host_d = BANK_EMPTY;
      default:    host_d = host_q;
    endcase
  end

  // Status flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      host_q <= BANK_EMPTY;
      compute_bank_q <= BANK_EMPTY;
    end
    else
    begin
      host_q <= host_d;
      compute_bank_q <= compute_bank_d;
    end
  end

  assign lk.host_st   = host_q;
  assign lk.compute_bank_st   = compute_bank_q;
  assign lk.swap_fire = swap_ok;
  assign lk.done_evt  = (compute_bank_q == BANK_IN_PROG) && (compute_bank_d == BANK_DONE);
  assign lk.empty_evt = (host_q == BANK_DONE) && (host_d == BANK_EMPTY);

  compute_bank_finish_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lk.compute_bank_done && compute_bank_q == BANK_IN_PROG && host_q == BANK_DONE &&
    !lk.release_req |=> compute_bank_q == BANK_DONE && host_q == BANK_DONE)
    else $error("compute_bank finish did not reach done with host kept");

  release_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lk.release_req && host_q == BANK_DONE && !lk.compute_bank_start &&
    !lk.compute_bank_done |=> host_q == BANK_EMPTY && $stable(compute_bank_q))
    else $error("release did not empty host or moved compute_bank bank");
endmodule : bank_status

// File: compute_bank_engine_model.sv
`timescale 1ns/1ps
module compute_bank_engine_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  output logic             compute_bank_start,
  output logic             compute_bank_done,
  output logic [39:0]      compute_bank_result
);
  // ----------------------------------------------------------
  // Compute engine stand-in
  // ----------------------------------------------------------
  // Quiet outputs until the bench asks for a calculation
  initial
  begin
    compute_bank_start  = 1'b0;
    compute_bank_done   = 1'b0;
    compute_bank_result = 40'h00_0000_0000;
  end

  // One start pulse; the calculation then runs
  task automatic start();
    @(posedge aclk);
    compute_bank_start <= aresetn;
    @(posedge aclk);
    compute_bank_start <= 1'b0;
  endtask : start

  // Finish after a delay; result only valid with the pulse
  task automatic finish(input logic [39:0] res, input int dly);
    repeat (dly) @(posedge aclk);
    compute_bank_result <= res;
    compute_bank_done   <= 1'b1;
    @(posedge aclk);
    compute_bank_done   <= 1'b0;
    compute_bank_result <= ~res;         // Stale result is not held
    @(posedge aclk);
  endtask : finish
endmodule : compute_bank_engine_model

// File: mult_accum_unit_tb_top.sv
`timescale 1ns/1ps
`include "mac_access_consts.svh"
module mult_accum_unit_tb_top;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        compute_bank_start;
  logic        compute_bank_done;
  logic [39:0] compute_bank_result;
  logic        irq;
  logic [1:0]  last_resp;
  logic [31:0] rd;
  logic [39:0] v;
  logic [39:0] a;
  int          err_count;
  int          compares;

  mult_accum_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compute_bank_start, .compute_bank_done,
    .compute_bank_result, .irq);

  compute_bank_engine_model eng (.aclk, .aresetn, .compute_bank_start, .compute_bank_done,
    .compute_bank_result);

  // ----------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------
  task automatic conclude();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit

  // Bounded wait; a hang ends the run
  task automatic guard(inout int n);
    n++;
    if (n > 200)
    begin
      err_count++;
      $display("mismatch bus wait exp answer got none");
      conclude();
    end
  endtask : guard

  // ----------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------
  task automatic axi_wr(input logic [7:0] ad, input logic [7:0] d);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
      guard(n);
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
      guard(n);
    end
  endtask : axi_rd

  // Status read against host and compute bank codes
  task automatic chk_stat(input logic [1:0] h, input logic [1:0] c);
    logic [31:0] s;
    axi_rd(`OFS_STAT, s);
    chk_word("status", {28'h000_0000, c, h}, s);
  endtask : chk_stat

  // ----------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------
  function automatic logic [39:0] ld_exp(input logic [39:0] x, input int s,
                                         input logic f);
    logic [39:0] m;
    m = (40'h00_0000_0001 << s) - 40'h00_0000_0001;
    return (x << s) | ({40{f}} & m);
  endfunction : ld_exp

  function automatic logic [7:0] rd_exp(input logic [39:0] x, input int k,
                                        input int r);
    logic signed [39:0] t;
    t = $signed(x) >>> r;
    return t[8*k +: 8];
  endfunction : rd_exp

  // ----------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial
  begin
    err_count = 0;
    compares = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_stat(`ST_EMPTY_CODE, `ST_EMPTY_CODE);
    axi_rd(8'h24, rd);
    chk_word("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, last_resp});
    axi_wr(8'h24, 8'h00);
    chk_word("unmapped wr resp", {30'h0, `RESP_SLVERR}, {30'h0, last_resp});
    // Every load shift with alternating fill, read back at 7 - s
    for (int s = 0; s < 8; s++)
    begin
      v = 40'h96_5A3C_E17B ^ {5{8'(s) * 8'h13}};
      axi_wr(`OFS_CTL, {1'b0, s[0], 3'h0, 3'(s)});
      for (int k = 0; k < 5; k++)
        axi_wr(8'(4 * k), v[8*k +: 8]);
      a = ld_exp(v, s, s[0]);
      axi_wr(`OFS_CTL, {2'h0, 3'(7 - s), 3'(s)});
      for (int k = 0; k < 5; k++)
      begin
        axi_rd(8'(4 * k), rd);
        chk_word("acc byte", {24'h0, rd_exp(a, k, 7 - s)}, rd);
      end
    end
    // Result with interrupt masked, then unmasked, then cleared
    axi_wr(`OFS_IRQ_MASK, 8'h00);
    axi_wr(`OFS_CTL, 8'h00);
    eng.start();
    eng.finish(40'hC0_1234_5678, 3);
    chk_stat(`ST_EMPTY_CODE, `ST_DONE_CODE);
    chk_bit("irq masked", 1'b0, irq);
    axi_wr(`OFS_IRQ_MASK, 8'h03);
    repeat (2) @(posedge aclk);
    chk_bit("irq", 1'b1, irq);
    axi_wr(`OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge aclk);
    chk_bit("irq cleared", 1'b0, irq);
    axi_wr(`OFS_STAT, `SWAP_CODE);
    chk_stat(`ST_DONE_CODE, `ST_EMPTY_CODE);
    a = 40'hC0_1234_5678;
    for (int k = 0; k < 4; k++)
    begin
      axi_rd(8'(4 * k), rd);
      chk_word("result", {24'h0, rd_exp(a, k, 0)}, rd);
    end
    chk_stat(`ST_DONE_CODE, `ST_EMPTY_CODE);
    // Final read of a block input while computing
    eng.start();
    chk_stat(`ST_DONE_CODE, `ST_INPROG_CODE);
    axi_rd(`OFS_FIN0, rd);
    chk_stat(`ST_EMPTY_CODE, `ST_INPROG_CODE);
    axi_rd(`OFS_IRQ_STAT, rd);
    chk_word("irq status", 32'h0000_0002, rd);
    eng.finish(40'h3F_0F0F_0F0F, 2);
    axi_wr(`OFS_STAT, `SWAP_CODE);
    // Compute finishes while host already holds a result
    eng.start();
    eng.finish(40'h81_2345_6789, 1);
    chk_stat(`ST_DONE_CODE, `ST_DONE_CODE);
    axi_rd(`OFS_ACC4, rd);
    chk_word("top byte", 32'h0000_003F, rd);
    chk_stat(`ST_EMPTY_CODE, `ST_DONE_CODE);
    axi_wr(`OFS_STAT, `SWAP_CODE);
    axi_wr(`OFS_STAT, 8'h00);
    chk_stat(`ST_DONE_CODE, `ST_EMPTY_CODE);
    axi_wr(`OFS_IRQ_MASK, 8'h03);
    chk_stat(`ST_EMPTY_CODE, `ST_EMPTY_CODE);
    axi_wr(`OFS_STAT, `SWAP_CODE);
    chk_stat(`ST_EMPTY_CODE, `ST_EMPTY_CODE);
    conclude();
  end
endmodule : mult_accum_unit_tb_top
